// ==== pkg/ycs_map.svh ====
`ifndef YCS_MAP_SVH
`define YCS_MAP_SVH

// register byte addresses
`define YCS_CTRL_ADR    32'h0000_0000
`define YCS_STAT_ADR    32'h0000_0004

// control register reset: both output buses released
`define YCS_CTRL_RST    12'h018

// status register field positions
`define YCS_STAT_STD    0
`define YCS_STAT_RATIO  2
`define YCS_STAT_DOT    3
`define YCS_STAT_CLAMP  4
`define YCS_STAT_LOE    5
`define YCS_STAT_COE    6

// converter pass-through delay, in half clock periods
`define YCS_CONV_HALF   7
`define YCS_CONV_CYC    ((`YCS_CONV_HALF + 1) / 2)

// luma pass-through extra delay and fixed pipeline stages
`define YCS_PT_EXTRA    15
`define YCS_PT_PIPE     3

// adaptive edge threshold
`define YCS_EDGE_TH     64

`endif

// ==== pkg/ycs_pkg.sv ====
package ycs_pkg;

    typedef enum logic [1:0] {
        YCS_NTSC,
        YCS_PAL,
        YCS_PAL_M,
        YCS_PAL_N
    } ycs_std_t;

    typedef struct packed {
        logic fixed_bandpass_sel;
        logic dot_reduce_sel;
        logic pal_variant_sel;
        logic luma_passthrough_sel;
        logic system_family_sel;
        logic ratio_setting;
        logic aperture_comp_en;
        logic chroma_out_enable_n;
        logic luma_out_enable_n;
        logic clamp_disable;
        logic input_source_sel;
        logic converter_passthrough_sel;
    } ycs_ctrl_t;

    typedef struct packed {
        logic       oe;
        logic [7:0] data;
    } ycs_bus_t;

endpackage : ycs_pkg

// ==== verilog/ycs_line_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

module ycs_line_mem #(
    parameter int W      = 8,
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // write port
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [W-1:0]      wr_data_i,
    // read port
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [W-1:0]      rd_data_o
);
    logic [W-1:0] mem [2**ADDR_W];

    always_ff @(posedge clk_i) begin
        mem[wr_addr_i] <= wr_data_i;
    end

    // read-before-write on a shared address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule : ycs_line_mem

`default_nettype wire

// ==== verilog/ycs_separator.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ycs_map.svh"

module ycs_separator #(
    parameter int EDGE_TH = `YCS_EDGE_TH
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // composite in and mode
    input  wire logic [7:0] x_i,
    input  wire logic       fixed_bp_i,
    // separated out
    output logic      [7:0] luma_o,
    output logic      [7:0] chroma_o
);
    import ycs_pkg::*;

    logic [4:0][7:0] tap;
    logic [4:0][7:0] next_tap;
    logic [7:0]      next_luma;
    logic [7:0]      next_chroma;
    int              c;
    int              d;
    int              y;

    always_comb begin
        c = 0;
        d = 0;
        y = 0;
        next_tap = {tap[3:0], x_i};
        // band-pass centred on fsc at 4fsc sampling
        c = (2 * int'(tap[2]) - int'(tap[0]) - int'(tap[4])) / 4;
        d = int'(tap[0]) - int'(tap[4]);
        if (d < 0) begin
            d = -d;
        end
        // adaptive: back off chroma across luma edges
        if (!fixed_bp_i && d > EDGE_TH) begin
            c = c / 2;
        end
        y = int'(tap[2]) - c;
        if (y < 0) begin
            y = 0;
        end else if (y > 255) begin
            y = 255;
        end
        next_luma   = 8'(y);
        next_chroma = 8'(c + 128);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tap      <= '0;
            luma_o   <= '0;
            chroma_o <= 8'h80;
        end else begin
            tap      <= next_tap;
            luma_o   <= next_luma;
            chroma_o <= next_chroma;
        end
    end

endmodule : ycs_separator

`default_nettype wire

// ==== verilog/ycs_top.sv ====
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ycs_map.svh"

module ycs_top #(
    parameter int NTSC_LINE = 910,
    parameter int PAL_LINE  = 1135,
    parameter int ADDR_W    = 12
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // video inputs
    input  wire logic [7:0]  digital_video_in_i,
    input  wire logic [7:0]  adc_sample_i,
    input  wire logic        clamp_pulse_n_i,
    // video outputs
    output var ycs_pkg::ycs_bus_t luma_out_bus_o,
    output var ycs_pkg::ycs_bus_t chroma_out_bus_o,
    output logic             clamp_active_o
);
    import ycs_pkg::*;

    localparam int CONV_CYC = `YCS_CONV_CYC;
    localparam logic [ADDR_W-1:0] NTSC_DIST =
        ADDR_W'(NTSC_LINE + `YCS_PT_EXTRA - `YCS_PT_PIPE);
    localparam logic [ADDR_W-1:0] PAL_DIST =
        ADDR_W'(2 * PAL_LINE + `YCS_PT_EXTRA - `YCS_PT_PIPE);

    // register file
    ycs_ctrl_t   ctrl;
    ycs_ctrl_t   next_ctrl;
    logic [31:0] next_dat;
    logic        next_ack;
    logic        req;

    // mode decode
    ycs_std_t    std;
    logic        pal_fam;
    logic        dot_eff;
    logic        ratio_eff;
    logic        chroma_oe;

    // datapath
    logic [7:0]               in_q;
    logic [7:0]               next_in;
    logic [CONV_CYC-1:0][7:0] conv;
    logic [CONV_CYC-1:0][7:0] next_conv;
    logic [ADDR_W-1:0]        wp;
    logic [ADDR_W-1:0]        next_wp;
    logic [ADDR_W-1:0]        ra;
    logic [7:0]               rd_q;
    logic [7:0]               sep_y;
    logic [7:0]               sep_c;
    logic [7:0]               ap_src;
    logic [7:0]               ap1;
    logic [7:0]               ap2;
    logic [7:0]               next_ap1;
    logic [7:0]               next_ap2;
    ycs_bus_t                 next_luma;
    ycs_bus_t                 next_chroma;
    logic                     next_clamp;
    int                       pk;

    // standard decode
    always_comb begin
        pal_fam = ctrl.system_family_sel;
        case ({ctrl.system_family_sel, ctrl.pal_variant_sel})
            2'b10: std = YCS_PAL;
            2'b11: std = ctrl.chroma_out_enable_n ? YCS_PAL_N : YCS_PAL_M;
            default: std = YCS_NTSC;
        endcase
        dot_eff   = pal_fam & ctrl.dot_reduce_sel;
        ratio_eff = ctrl.ratio_setting & ~dot_eff;
        if (std == YCS_PAL_M || std == YCS_PAL_N) begin
            chroma_oe = ~ctrl.luma_out_enable_n;
        end else begin
            chroma_oe = ~ctrl.chroma_out_enable_n;
        end
    end

    // wishbone slave, one wait state
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_comb begin
        next_ctrl = ctrl;
        next_dat  = 32'h0000_0000;
        next_ack  = req;
        if (req && wb_adr_i == `YCS_CTRL_ADR) begin
            if (wb_we_i && wb_sel_i[0]) begin
                next_ctrl[7:0] = wb_dat_i[7:0];
            end
            if (wb_we_i && wb_sel_i[1]) begin
                next_ctrl[11:8] = wb_dat_i[11:8];
            end
            next_dat[11:0] = ctrl;
        end else if (req && wb_adr_i == `YCS_STAT_ADR) begin
            next_dat[`YCS_STAT_STD +: 2] = std;
            next_dat[`YCS_STAT_RATIO]    = ratio_eff;
            next_dat[`YCS_STAT_DOT]      = dot_eff;
            next_dat[`YCS_STAT_CLAMP]    = clamp_active_o;
            next_dat[`YCS_STAT_LOE]      = luma_out_bus_o.oe;
            next_dat[`YCS_STAT_COE]      = chroma_out_bus_o.oe;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= ycs_ctrl_t'(`YCS_CTRL_RST);
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else begin
            ctrl     <= next_ctrl;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
        end
    end

    // input capture and line delay
    always_comb begin
        if (ctrl.input_source_sel) begin
            next_in = digital_video_in_i;
        end else begin
            next_in = adc_sample_i;
        end
        next_conv = {conv[CONV_CYC-2:0], adc_sample_i};
        next_wp   = wp + 1'b1;
        ra        = wp - (pal_fam ? PAL_DIST : NTSC_DIST);
    end

    ycs_line_mem #(
        .W      (8),
        .ADDR_W (ADDR_W)
    ) u_mem (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_addr_i (wp),
        .wr_data_i (in_q),
        .rd_addr_i (ra),
        .rd_data_o (rd_q)
    );

    ycs_separator u_sep (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .x_i        (in_q),
        .fixed_bp_i (ctrl.fixed_bandpass_sel),
        .luma_o     (sep_y),
        .chroma_o   (sep_c)
    );

    // aperture peaking and output muxing
    always_comb begin
        pk       = 0;
        ap_src   = ctrl.luma_passthrough_sel ? rd_q : sep_y;
        next_ap1 = ap_src;
        next_ap2 = ap1;
        next_luma.data = ap1;
        if (ctrl.aperture_comp_en) begin
            pk = int'(ap1) + (2 * int'(ap1) - int'(ap_src) - int'(ap2)) / 4;
            if (pk < 0) begin
                pk = 0;
            end else if (pk > 255) begin
                pk = 255;
            end
            next_luma.data = 8'(pk);
        end
        if (ctrl.converter_passthrough_sel) begin
            next_luma.data = conv[CONV_CYC-1];
        end
        next_luma.oe     = ~ctrl.luma_out_enable_n;
        next_chroma.data = sep_c;
        next_chroma.oe   = chroma_oe;
        next_clamp = ~ctrl.clamp_disable & ~clamp_pulse_n_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_q             <= 8'h00;
            conv             <= '0;
            wp               <= '0;
            ap1              <= 8'h00;
            ap2              <= 8'h00;
            luma_out_bus_o   <= '0;
            chroma_out_bus_o <= '0;
            clamp_active_o   <= 1'b0;
        end else begin
            in_q             <= next_in;
            conv             <= next_conv;
            wp               <= next_wp;
            ap1              <= next_ap1;
            ap2              <= next_ap2;
            luma_out_bus_o   <= next_luma;
            chroma_out_bus_o <= next_chroma;
            clamp_active_o   <= next_clamp;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_conv_thru_delay: assert property (
        $past(ctrl.converter_passthrough_sel)
        |-> luma_out_bus_o.data == $past(adc_sample_i, 5))
        else $error("converter pass-through sample or delay wrong");
    chk_source_select: assert property (
        $past(ctrl.input_source_sel) |-> in_q == $past(digital_video_in_i))
        else $error("filter source not the digital input");
    chk_ntsc_tap: assert property (
        !pal_fam |-> ADDR_W'(wp - ra) == NTSC_DIST)
        else $error("ntsc line tap distance wrong");
    chk_pal_tap: assert property (
        pal_fam |-> ADDR_W'(wp - ra) == PAL_DIST)
        else $error("pal line tap distance wrong");
    chk_luma_enable: assert property (
        ##1 luma_out_bus_o.oe == !$past(ctrl.luma_out_enable_n))
        else $error("luma bus enable wrong");
    chk_chroma_shared: assert property (
        $past(std == YCS_PAL_M || std == YCS_PAL_N)
        |-> chroma_out_bus_o.oe == luma_out_bus_o.oe)
        else $error("chroma enable not tied to luma in variant mode");
    chk_chroma_own: assert property (
        $past(std == YCS_NTSC || std == YCS_PAL)
        |-> chroma_out_bus_o.oe == !$past(ctrl.chroma_out_enable_n))
        else $error("chroma bus enable wrong");
    chk_clamp_gate: assert property (
        clamp_active_o |-> $past(!clamp_pulse_n_i && !ctrl.clamp_disable))
        else $error("clamp active without pulse");
    chk_ratio_force: assert property (
        $past(req && dot_eff && wb_adr_i == `YCS_STAT_ADR)
        |-> !wb_dat_o[`YCS_STAT_RATIO]) else $error("ratio not forced low");
    chk_chroma_thru: assert property (
        $past(ctrl.luma_passthrough_sel)
        |-> chroma_out_bus_o.data == $past(sep_c))
        else $error("chroma lost during luma pass-through");
    chk_wb_ack: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not a single pulse");

    cov_ntsc_thru: cover property (
        !pal_fam && ctrl.luma_passthrough_sel && luma_out_bus_o.oe);
    cov_pal_n: cover property (std == YCS_PAL_N && chroma_out_bus_o.oe);
    cov_conv_thru: cover property (ctrl.converter_passthrough_sel ##4 1);
    cov_ctrl_write: cover property (req && wb_we_i);

endmodule : ycs_top

`default_nettype wire

// ==== verification/ycs_video_src.sv ====
`timescale 1ns/1ps
`default_nettype none

module ycs_video_src (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // output buses of the block
    input  var ycs_pkg::ycs_bus_t luma_i,
    input  var ycs_pkg::ycs_bus_t chroma_i,
    // composite source
    output logic [7:0]            dig_o,
    output logic [7:0]            adc_o,
    output logic [7:0]            cnt_o,
    // resolved bus wires
    output logic [7:0]            luma_wire_o,
    output logic [7:0]            chroma_wire_o
);
    import ycs_pkg::*;

    logic [7:0] cnt;
    logic [7:0] luma_last;
    logic [7:0] chroma_last;

    // ramp stepped on each rising master clock edge, same clock for converter
    always_ff @(posedge clk_i) begin
        cnt <= rst_i ? 8'h00 : cnt + 8'h01;
        if (luma_i.oe) luma_last <= luma_i.data;
        if (chroma_i.oe) chroma_last <= chroma_i.data;
    end

    assign cnt_o = cnt;
    assign adc_o = cnt;
    // digital path differs from converter path so the source is visible
    assign dig_o = cnt ^ 8'ha5;
    // a released bus shows the inverse of its last value, never a stale copy
    assign luma_wire_o   = luma_i.oe ? luma_i.data : ~luma_last;
    assign chroma_wire_o = chroma_i.oe ? chroma_i.data : ~chroma_last;
endmodule : ycs_video_src

`default_nettype wire

// ==== verification/ycs_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ycs_map.svh"

module ycs_top_tb;
    import ycs_pkg::*;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [31:0] wb_adr = 32'h0000_0000;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic        wb_we = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic [3:0]  wb_sel = 4'h0;
    logic [3:0]  sel_req = 4'h3;
    logic        clamp_n = 1'b1;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        clamp_act;
    logic [7:0]  dig, adc, cnt, luma_w, chroma_w;
    ycs_bus_t    luma, chroma;
    logic [31:0] rd;
    int          errors = 0;
    int          compares = 0;
    int          cycles = 0;

    ycs_top #(.NTSC_LINE(20), .PAL_LINE(30), .ADDR_W(12)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .digital_video_in_i(dig), .adc_sample_i(adc),
        .clamp_pulse_n_i(clamp_n), .luma_out_bus_o(luma),
        .chroma_out_bus_o(chroma), .clamp_active_o(clamp_act));

    ycs_video_src u_src (
        .clk_i(clk_i), .rst_i(rst_i), .luma_i(luma), .chroma_i(chroma),
        .dig_o(dig), .adc_o(adc), .cnt_o(cnt), .luma_wire_o(luma_w),
        .chroma_wire_o(chroma_w));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb_xfer(input logic we, input logic [31:0] adr,
                           input logic [31:0] dat, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_sel <= sel_req;
        wb_adr <= adr;
        wb_dat <= dat;
        // ack and read data taken at the rising edge that samples ack high
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) errors++;
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        wb_sel <= 4'h0;
    endtask : wb_xfer

    task automatic set_ctrl(input logic [11:0] v);
        wb_xfer(1'b1, `YCS_CTRL_ADR, {20'h0_0000, v}, rd);
        @(negedge clk_i);
    endtask : set_ctrl

    // luma wire must equal the source ramp seen lag+1 edges earlier
    task automatic stream_chk(input int lag, input logic [7:0] mask);
        repeat (2 * lag) @(negedge clk_i);
        repeat (8) begin
            @(negedge clk_i);
            chk({24'h0, luma_w}, {24'h0, 8'(cnt - lag - 1) ^ mask});
        end
    endtask : stream_chk

    int m;
    int l;
    logic fam, cn, dt, rt;
    int diff;
    logic [11:0] c;

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, `YCS_CTRL_ADR, 32'h0, rd);
        chk(rd, 32'h0000_0018);
        chk({31'h0, luma.oe | chroma.oe}, 32'h0);
        wb_xfer(1'b1, 32'h0000_0010, 32'h0000_0fff, rd);
        wb_xfer(1'b0, 32'h0000_0010, 32'h0, rd);
        chk(rd, 32'h0);
        wb_xfer(1'b0, `YCS_CTRL_ADR, 32'h0, rd);
        chk(rd, 32'h0000_0018);
        // low lane only: upper control bits must keep their value
        sel_req = 4'h1;
        wb_xfer(1'b1, `YCS_CTRL_ADR, 32'h0000_0fe7, rd);
        sel_req = 4'h3;
        wb_xfer(1'b0, `YCS_CTRL_ADR, 32'h0, rd);
        chk(rd, 32'h0000_00e7);
        $display("test reset_regs done");

        set_ctrl(12'h011);
        chk({30'h0, luma.oe, chroma.oe}, 32'h0000_0002);
        stream_chk(4, 8'h00);
        $display("test converter_through done");

        set_ctrl(12'h102);
        chk({31'h0, chroma.oe}, 32'h0000_0001);
        stream_chk(35, 8'ha5);
        set_ctrl(12'h1c0);
        stream_chk(75, 8'h00);
        // a ramp carries no subcarrier: chroma sits at its zero code
        while (cnt != 8'h40) @(negedge clk_i);
        chk({24'h0, chroma_w}, 32'h0000_0080);
        $display("test luma_through done");

        set_ctrl(12'h120);
        stream_chk(35, 8'h00);
        set_ctrl(12'h122);
        repeat (80) @(negedge clk_i);
        diff = 0;
        repeat (8) begin
            @(negedge clk_i);
            if (luma_w !== (8'(cnt - 36) ^ 8'ha5)) begin
                diff++;
            end
        end
        chk(32'(diff != 0), 32'h0000_0001);
        $display("test aperture done");

        for (m = 0; m < 4; m++) begin
            for (l = 0; l < 2; l++) begin
                fam = (m != 0);
                cn = (m == 3);
                dt = fam & l[0];
                rt = fam & !l[0];
                c = (12'(fam) << 7) | (12'(fam) << 6) | (12'(dt) << 10)
                    | (12'(m >= 2) << 9) | (12'(cn) << 4) | (12'(l) << 3);
                set_ctrl(c);
                wb_xfer(1'b0, `YCS_STAT_ADR, 32'h0, rd);
                chk(rd, {25'h0, (m >= 2) ? !l[0] : !cn, !l[0], 1'b0,
                         dt, rt, 2'(m)});
                chk({30'h0, luma.oe, chroma.oe},
                    {30'h0, !l[0], (m >= 2) ? !l[0] : !cn});
            end
        end
        $display("test mode_decode done");

        set_ctrl(12'h000);
        @(posedge clk_i);
        clamp_n <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk({31'h0, clamp_act}, 32'h0000_0001);
        @(posedge clk_i);
        clamp_n <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk({31'h0, clamp_act}, 32'h0);
        set_ctrl(12'h004);
        @(posedge clk_i);
        clamp_n <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk({31'h0, clamp_act}, 32'h0);
        @(posedge clk_i);
        clamp_n <= 1'b1;
        $display("test clamp done");
        wrap_up();
    end
endmodule : ycs_top_tb

`default_nettype wire
